//--- design/cdcs_regs.sv
// Control/status register set and BAR routing for a chained DMA endpoint.
// Assumes the transaction layer presents one decoded request per cycle and
// accepts one completion per cycle; the DMA engines sample cfg outputs.
//
// Function
// [R01] BAR0/1/4/5 and pairs route to 32 KByte target memory, skipping DMA.
// [R02] BAR2/3 and pair route to the DMA register space of 256 bytes.
// [R03] Host never targets expansion ROM or I/O BARs; unimplemented.
// [R04] Offsets are byte offsets from BAR2/BAR3 base; registers 32 bits.
// [R05] Control word 0x0/0x10: control field 31:16, descriptor count 15:0.
// [R06] Write words 0x4/0x8 hold upper/lower write table base address.
// [R07] Read words 0x14/0x18 hold upper/lower read table base address.
// [R08] Words 0xC/0x1C carry last descriptor index in 15:0, rest reserved.
// [R09] All eight control words read back their last written value.
// [R10] Bit 17 set: interrupt per completed descriptor; clear: none.
// [R11] Bit 18 set: write completed descriptor number back to host table.
// [R12] Bits 24:20 drive interrupt vector; default read 0, write 1.
// [R13] Bits 30:28 drive interrupt traffic class, default zero.
// [R14] Bit 31 clear stops at last descriptor; set loops until cleared.
// [R15] Status words 0x20-0x30 are read-only; writes ignored.
// [R16] 0x2C: tag limit in top byte plus read cycle counter.
// [R17] 0x30 counts ECRC errors only while ECRC forwarding enabled.
// [R18] Status high: last completed descriptor 15:0, FIFO empty bit 16.
// [R19] Progress write-back targets header offset 0xC in host memory.
// [R20] 0x24: target address width top byte plus write cycle counter.
// [R21] Reads answered with completion; writes take effect next cycle.
`timescale 1ns/1ps
`default_nettype none

module cdcs_regs
   import cdcs_pkg::*;
#(
   parameter int CNT_W = 24,
   parameter logic [7:0] TAG_LIMIT = 8'h20
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire cdcs_req_t req_i,
   input wire cdcs_prog_t wr_prog_i,
   input wire cdcs_prog_t rd_prog_i,
   input wire logic ecrc_fwd_en_i,
   input wire logic ecrc_err_i,
   output logic cpl_valid_o,
   output logic [31:0] cpl_data_o,
   output logic tgt_valid_o,
   output logic tgt_write_o,
   output logic [TGT_ADDR_W-1:0] tgt_addr_o,
   output logic [31:0] tgt_wdata_o,
   output cdcs_cfg_t wr_cfg_o,
   output cdcs_cfg_t rd_cfg_o,
   output logic wr_irq_req_o,
   output logic rd_irq_req_o,
   output logic wb_valid_o,
   output logic [63:0] wb_addr_o,
   output logic [31:0] wb_data_o,
   output logic [4:0] app_interrupt_vector_o,
   output logic [2:0] app_interrupt_class_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   logic hit_tgt;
   logic hit_csr;
   logic [7:0] off;
   logic csr_wr;
   logic csr_rd;

   // Both bits of a 64-bit pair may be set; either one routes
   // BARs 0,1,4,5 to target memory; ROM and I/O BARs never hit here
   assign hit_tgt = req_i.valid & (req_i.bar_hit[BAR_0] | req_i.bar_hit[BAR_1] |
                    req_i.bar_hit[BAR_4] | req_i.bar_hit[BAR_5]); // [R01] [R03]
   assign hit_csr = req_i.valid & (req_i.bar_hit[BAR_2] | req_i.bar_hit[BAR_3])
                    & ~hit_tgt; // [R02]
   // 256-byte window, word aligned
   assign off = {req_i.addr[7:2], 2'b00}; // [R04]
   assign csr_wr = hit_csr & req_i.write;
   assign csr_rd = hit_csr & ~req_i.write;

   ////////////////////////////////////////////////////////////////////////////
   // Control words
   logic [31:0] wr_ctrl_reg, wr_base_hi_reg, wr_base_lo_reg, wr_last_reg;
   logic [31:0] rd_ctrl_reg, rd_base_hi_reg, rd_base_lo_reg, rd_last_reg;

   // Vector defaults: read engine 0, write engine 1
   localparam logic [31:0] WR_CTRL_RESET = CTRL_RESET | (32'h1 << CTL_VEC_LSB);

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wr_ctrl_reg <= WR_CTRL_RESET; // [R12] [R13]
         wr_base_hi_reg <= CTRL_RESET;
         wr_base_lo_reg <= CTRL_RESET;
         wr_last_reg <= CTRL_RESET;
         rd_ctrl_reg <= CTRL_RESET;
         rd_base_hi_reg <= CTRL_RESET;
         rd_base_lo_reg <= CTRL_RESET;
         rd_last_reg <= CTRL_RESET;
      end else if (csr_wr) begin
         // Visible to engines two cycles after the write
         case (off)
            OFF_WR_CTRL: wr_ctrl_reg <= req_i.wdata; // [R05] [R09] [R21]
            OFF_WR_BASE_HI: wr_base_hi_reg <= req_i.wdata; // [R06]
            OFF_WR_BASE_LO: wr_base_lo_reg <= req_i.wdata; // [R06]
            OFF_WR_LAST: wr_last_reg <= req_i.wdata; // [R08]
            OFF_RD_CTRL: rd_ctrl_reg <= req_i.wdata; // [R05]
            OFF_RD_BASE_HI: rd_base_hi_reg <= req_i.wdata; // [R07]
            OFF_RD_BASE_LO: rd_base_lo_reg <= req_i.wdata; // [R07]
            OFF_RD_LAST: rd_last_reg <= req_i.wdata; // [R08]
            default: ; // Status words ignore writes [R15]
         endcase
      end
   end

   function automatic cdcs_cfg_t pack_cfg(input logic [31:0] ctl,
                                          input logic [31:0] hi,
                                          input logic [31:0] lo,
                                          input logic [31:0] last);
      cdcs_cfg_t c;
      c.desc_count = ctl[15:0]; // [R05]
      c.last_index = last[15:0]; // [R08]
      c.table_base = {hi, lo};
      c.irq_enable = ctl[CTL_IRQ_EN_BIT];
      c.writeback_enable = ctl[CTL_WB_EN_BIT];
      c.vector = ctl[CTL_VEC_MSB:CTL_VEC_LSB];
      c.tclass = ctl[CTL_TC_MSB:CTL_TC_LSB];
      c.loop_forever = ctl[CTL_LOOP_BIT]; // [R14]
      return c;
   endfunction

   // One cycle behind the registers; engines see a write two cycles after it
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wr_cfg_o <= '0;
         rd_cfg_o <= '0;
      end else begin
         wr_cfg_o <= pack_cfg(wr_ctrl_reg, wr_base_hi_reg, wr_base_lo_reg, wr_last_reg);
         rd_cfg_o <= pack_cfg(rd_ctrl_reg, rd_base_hi_reg, rd_base_lo_reg, rd_last_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Progress status and performance counters
   logic [15:0] wr_done_reg, rd_done_reg;
   logic wr_empty_reg, rd_empty_reg;
   logic [CNT_W-1:0] wr_cyc_reg, rd_cyc_reg;
   logic wr_run_reg, rd_run_reg;
   logic [31:0] ecrc_cnt_reg;

   // Counting stops on the final descriptor unless looping
   // Start wins over a coincident final descriptor
   function automatic logic run_next(input logic run, input cdcs_prog_t p,
                                     input logic [15:0] last, input logic loop);
      if (p.start) begin
         return 1'b1;
      end else if (p.desc_done && p.done_index == last && !loop) begin
         return 1'b0; // [R14]
      end else begin
         return run;
      end
   endfunction

   // Saturates instead of wrapping, so a long run never reads as short
   function automatic logic [CNT_W-1:0] cyc_next(input logic [CNT_W-1:0] cyc,
                                                 input logic run,
                                                 input logic start);
      if (start) begin
         return '0;
      end else if (run && cyc != {CNT_W{1'b1}}) begin
         return cyc + 1'b1;
      end else begin
         return cyc;
      end
   endfunction

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wr_run_reg <= 1'b0;
         rd_run_reg <= 1'b0;
         wr_cyc_reg <= '0;
         rd_cyc_reg <= '0;
      end else begin
         wr_run_reg <= run_next(wr_run_reg, wr_prog_i, wr_last_reg[15:0],
                                wr_ctrl_reg[CTL_LOOP_BIT]);
         rd_run_reg <= run_next(rd_run_reg, rd_prog_i, rd_last_reg[15:0],
                                rd_ctrl_reg[CTL_LOOP_BIT]);
         wr_cyc_reg <= cyc_next(wr_cyc_reg, wr_run_reg, wr_prog_i.start); // [R20]
         rd_cyc_reg <= cyc_next(rd_cyc_reg, rd_run_reg, rd_prog_i.start); // [R16]
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wr_done_reg <= '0;
         rd_done_reg <= '0;
         wr_empty_reg <= 1'b1;
         rd_empty_reg <= 1'b1;
      end else begin
         if (wr_prog_i.desc_done) begin
            wr_done_reg <= wr_prog_i.done_index; // [R18]
         end
         if (rd_prog_i.desc_done) begin
            rd_done_reg <= rd_prog_i.done_index; // [R18]
         end
         wr_empty_reg <= wr_prog_i.fifo_empty;
         rd_empty_reg <= rd_prog_i.fifo_empty;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         // Saturating count; only reset clears it
         ecrc_cnt_reg <= CNT_RESET;
      end else if (ecrc_fwd_en_i && ecrc_err_i && ecrc_cnt_reg != 32'hFFFF_FFFF) begin
         ecrc_cnt_reg <= ecrc_cnt_reg + 32'h1; // [R17]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-descriptor interrupt and progress write-back
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wr_irq_req_o <= 1'b0;
         rd_irq_req_o <= 1'b0;
         // Levels: they keep the last request's vector and class
         app_interrupt_vector_o <= '0;
         app_interrupt_class_o <= '0;
      end else begin
         wr_irq_req_o <= wr_prog_i.desc_done & wr_ctrl_reg[CTL_IRQ_EN_BIT]; // [R10]
         rd_irq_req_o <= rd_prog_i.desc_done & rd_ctrl_reg[CTL_IRQ_EN_BIT]; // [R10]
         // Read engine wins the vector when both finish together
         if (rd_prog_i.desc_done && rd_ctrl_reg[CTL_IRQ_EN_BIT]) begin
            app_interrupt_vector_o <= rd_ctrl_reg[CTL_VEC_MSB:CTL_VEC_LSB]; // [R12]
            app_interrupt_class_o <= rd_ctrl_reg[CTL_TC_MSB:CTL_TC_LSB]; // [R13]
         end else if (wr_prog_i.desc_done && wr_ctrl_reg[CTL_IRQ_EN_BIT]) begin
            app_interrupt_vector_o <= wr_ctrl_reg[CTL_VEC_MSB:CTL_VEC_LSB]; // [R12]
            app_interrupt_class_o <= wr_ctrl_reg[CTL_TC_MSB:CTL_TC_LSB]; // [R13]
         end
      end
   end

   logic wb_wr_hit, wb_rd_hit;
   logic wb_pend_reg;
   logic [15:0] wb_pend_idx_reg;

   assign wb_wr_hit = wr_prog_i.desc_done & wr_ctrl_reg[CTL_WB_EN_BIT];
   assign wb_rd_hit = rd_prog_i.desc_done & rd_ctrl_reg[CTL_WB_EN_BIT];

   // One write-back per cycle; a coincident write-engine one is held until a cycle with no read-engine one
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wb_valid_o <= 1'b0;
         wb_addr_o <= '0;
         wb_data_o <= '0;
         wb_pend_reg <= 1'b0;
         wb_pend_idx_reg <= '0;
      end else begin
         wb_valid_o <= wb_rd_hit | wb_wr_hit | wb_pend_reg;
         // Write-engine entry waits while the slot is taken; a newer one arriving with a read hit replaces it
         wb_pend_reg <= (wb_wr_hit & (wb_rd_hit | wb_pend_reg)) | (wb_pend_reg & wb_rd_hit);
         if (wb_wr_hit) begin
            wb_pend_idx_reg <= wr_prog_i.done_index;
         end
         if (wb_rd_hit) begin
            wb_addr_o <= {rd_base_hi_reg, rd_base_lo_reg} + HDR_PROGRESS_OFF; // [R19]
            wb_data_o <= {16'h0000, rd_prog_i.done_index}; // [R11]
         end else if (wb_pend_reg) begin
            wb_addr_o <= {wr_base_hi_reg, wr_base_lo_reg} + HDR_PROGRESS_OFF;
            wb_data_o <= {16'h0000, wb_pend_idx_reg};
         end else if (wb_wr_hit) begin
            wb_addr_o <= {wr_base_hi_reg, wr_base_lo_reg} + HDR_PROGRESS_OFF; // [R19]
            wb_data_o <= {16'h0000, wr_prog_i.done_index}; // [R11]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Target memory forward and read completions
   logic [31:0] rd_mux;
   logic [7:0] addr_w8;
   logic [CNT_W-1:0] cnt_sat_w, cnt_sat_r;

   assign addr_w8 = 8'(TGT_ADDR_W);
   assign cnt_sat_w = wr_cyc_reg;
   assign cnt_sat_r = rd_cyc_reg;

   // Unmapped offsets read as zero rather than aliasing a register
   always_comb begin
      case (off)
         OFF_WR_CTRL: rd_mux = wr_ctrl_reg; // [R09]
         OFF_WR_BASE_HI: rd_mux = wr_base_hi_reg;
         OFF_WR_BASE_LO: rd_mux = wr_base_lo_reg;
         OFF_WR_LAST: rd_mux = wr_last_reg;
         OFF_RD_CTRL: rd_mux = rd_ctrl_reg;
         OFF_RD_BASE_HI: rd_mux = rd_base_hi_reg;
         OFF_RD_BASE_LO: rd_mux = rd_base_lo_reg;
         OFF_RD_LAST: rd_mux = rd_last_reg;
         OFF_WR_STAT_HI: rd_mux = {15'h0000, wr_empty_reg, wr_done_reg}; // [R18]
         OFF_WR_STAT_LO: rd_mux = {addr_w8, 24'(cnt_sat_w)}; // [R20]
         OFF_RD_STAT_HI: rd_mux = {15'h0000, rd_empty_reg, rd_done_reg}; // [R18]
         OFF_RD_STAT_LO: rd_mux = {TAG_LIMIT, 24'(cnt_sat_r)}; // [R16]
         OFF_ERR_STAT: rd_mux = ecrc_cnt_reg; // [R17]
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         cpl_valid_o <= 1'b0;
         cpl_data_o <= '0;
      end else begin
         // Data zero between completions so stale reads cannot leak
         cpl_valid_o <= csr_rd; // [R21]
         cpl_data_o <= csr_rd ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tgt_valid_o <= 1'b0;
         tgt_write_o <= 1'b0;
         tgt_addr_o <= '0;
         tgt_wdata_o <= '0;
      end else begin
         tgt_valid_o <= hit_tgt; // [R01]
         tgt_write_o <= hit_tgt & req_i.write;
         // Bits above the 32 KByte window are dropped, so accesses alias
         tgt_addr_o <= req_i.addr[TGT_ADDR_W-1:0];
         tgt_wdata_o <= req_i.wdata;
      end
   end

endmodule

`default_nettype wire

//--- design/cdcs_pkg.sv
// Package for the chained DMA control and status block.
// Assumes one application clock and a synchronous active-low reset.
package cdcs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets within the control/status BAR window
   localparam logic [7:0] OFF_WR_CTRL = 8'h00;
   localparam logic [7:0] OFF_WR_BASE_HI = 8'h04;
   localparam logic [7:0] OFF_WR_BASE_LO = 8'h08;
   localparam logic [7:0] OFF_WR_LAST = 8'h0C;
   localparam logic [7:0] OFF_RD_CTRL = 8'h10;
   localparam logic [7:0] OFF_RD_BASE_HI = 8'h14;
   localparam logic [7:0] OFF_RD_BASE_LO = 8'h18;
   localparam logic [7:0] OFF_RD_LAST = 8'h1C;
   localparam logic [7:0] OFF_WR_STAT_HI = 8'h20;
   localparam logic [7:0] OFF_WR_STAT_LO = 8'h24;
   localparam logic [7:0] OFF_RD_STAT_HI = 8'h28;
   localparam logic [7:0] OFF_RD_STAT_LO = 8'h2C;
   localparam logic [7:0] OFF_ERR_STAT = 8'h30;

   ////////////////////////////////////////////////////////////////////////////
   // Control and status field bit positions
   localparam int CTL_IRQ_EN_BIT = 17;
   localparam int CTL_WB_EN_BIT = 18;
   localparam int CTL_VEC_LSB = 20;
   localparam int CTL_VEC_MSB = 24;
   localparam int CTL_TC_LSB = 28;
   localparam int CTL_TC_MSB = 30;
   localparam int CTL_LOOP_BIT = 31;
   localparam int STAT_FIFO_EMPTY_BIT = 16;

   // Target memory size, and progress location in the table header
   localparam int TGT_MEM_BYTES = 32768;
   localparam int TGT_ADDR_W = 15;
   localparam logic [63:0] HDR_PROGRESS_OFF = 64'h0000_0000_0000_000C;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CNT_RESET = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // BAR hit vector index
   typedef enum logic [2:0] {
      BAR_0, BAR_1, BAR_2, BAR_3, BAR_4, BAR_5
   } cdcs_bar_t;

   // Incoming host memory request
   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] bar_hit;
      logic [31:0] addr;
      logic [31:0] wdata;
   } cdcs_req_t;

   // Per-engine settings presented to the DMA engine
   typedef struct packed {
      logic [15:0] desc_count;
      logic [15:0] last_index;
      logic [63:0] table_base;
      logic irq_enable;
      logic writeback_enable;
      logic [4:0] vector;
      logic [2:0] tclass;
      logic loop_forever;
   } cdcs_cfg_t;

   // Per-engine progress from the DMA engine
   typedef struct packed {
      logic start;
      logic desc_done;
      logic [15:0] done_index;
      logic fifo_empty;
   } cdcs_prog_t;

endpackage

//--- test/cdcs_regs_checker.sv
// Port-level assertions for the DMA control/status register block.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module cdcs_regs_checker
   import cdcs_pkg::*;
#(
   parameter int CNT_W = 24,
   parameter logic [7:0] TAG_LIMIT = 8'h20
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire cdcs_req_t req_i,
   input wire cdcs_prog_t wr_prog_i,
   input wire cdcs_prog_t rd_prog_i,
   input wire logic ecrc_fwd_en_i,
   input wire logic ecrc_err_i,
   input wire logic cpl_valid_o,
   input wire logic [31:0] cpl_data_o,
   input wire logic tgt_valid_o,
   input wire logic tgt_write_o,
   input wire logic [TGT_ADDR_W-1:0] tgt_addr_o,
   input wire logic [31:0] tgt_wdata_o,
   input wire cdcs_cfg_t wr_cfg_o,
   input wire cdcs_cfg_t rd_cfg_o,
   input wire logic wr_irq_req_o,
   input wire logic rd_irq_req_o,
   input wire logic wb_valid_o,
   input wire logic [63:0] wb_addr_o,
   input wire logic [31:0] wb_data_o,
   input wire logic [4:0] app_interrupt_vector_o,
   input wire logic [2:0] app_interrupt_class_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Target BARs win over register BARs when both hit
   wire logic tgt_hit = req_i.valid && (|{req_i.bar_hit[5:4], req_i.bar_hit[1:0]});
   wire logic reg_hit = req_i.valid && (|req_i.bar_hit[3:2]) && !tgt_hit;
   wire logic reg_rd = reg_hit && !req_i.write;
   wire logic rdctl_wr = reg_hit && req_i.write && req_i.addr[7:2] == 6'h04;
   wire logic wrlo_wr = reg_hit && req_i.write && req_i.addr[7:2] == 6'h02;
   wire logic [31:0] wd = req_i.wdata;
   wire logic [14:0] ta = req_i.addr[14:0];
   wire logic [31:0] rd_view = {rd_cfg_o.loop_forever, rd_cfg_o.tclass, 3'h0, rd_cfg_o.vector,
      1'b0, rd_cfg_o.writeback_enable, rd_cfg_o.irq_enable, 1'b0, rd_cfg_o.desc_count};

   cpl_after_read_a: assert property (reg_rd |=> cpl_valid_o)
      else $error("register read got no completion");
   cpl_cause_a: assert property (cpl_valid_o |-> $past(reg_rd))
      else $error("completion without register read");
   cpl_idle_a: assert property (!cpl_valid_o |-> cpl_data_o == 32'h0000_0000)
      else $error("completion data not cleared");
   tgt_route_a: assert property (tgt_hit |=> tgt_valid_o && !cpl_valid_o
      && tgt_addr_o == $past(ta) && tgt_write_o == $past(req_i.write))
      else $error("target request not forwarded");
   tgt_cause_a: assert property (tgt_valid_o |-> $past(tgt_hit))
      else $error("target forward without target hit");
   rd_ctl_a: assert property (rdctl_wr ##1 1'b1 |=>
      rd_view == ($past(wd, 2) & 32'hF1F6_FFFF))
      else $error("read control fields wrong");
   wr_base_a: assert property (wrlo_wr ##1 1'b1 |=>
      wr_cfg_o.table_base[31:0] == $past(wd, 2))
      else $error("write table base low wrong");
   wr_irq_a: assert property (wr_irq_req_o ==
      ($past(wr_prog_i.desc_done) && wr_cfg_o.irq_enable))
      else $error("write interrupt request mismatch");
   rd_irq_a: assert property (rd_irq_req_o ==
      ($past(rd_prog_i.desc_done) && rd_cfg_o.irq_enable))
      else $error("read interrupt request mismatch");
   wb_read_a: assert property (rd_prog_i.desc_done |=>
      wb_valid_o == rd_cfg_o.writeback_enable
      && (!wb_valid_o || (wb_data_o == {16'h0000, $past(rd_prog_i.done_index)}
      && wb_addr_o == rd_cfg_o.table_base + HDR_PROGRESS_OFF)))
      else $error("progress write-back wrong");

   cover property (reg_rd ##1 cpl_valid_o);
   cover property (tgt_hit ##1 tgt_valid_o);
   cover property (rd_prog_i.desc_done && wr_prog_i.desc_done);
   cover property (wb_valid_o ##1 wb_valid_o);
endmodule

bind cdcs_regs cdcs_regs_checker #(.CNT_W(CNT_W), .TAG_LIMIT(TAG_LIMIT)) u_chk (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .wr_prog_i(wr_prog_i),
   .rd_prog_i(rd_prog_i), .ecrc_fwd_en_i(ecrc_fwd_en_i), .ecrc_err_i(ecrc_err_i),
   .cpl_valid_o(cpl_valid_o), .cpl_data_o(cpl_data_o), .tgt_valid_o(tgt_valid_o),
   .tgt_write_o(tgt_write_o), .tgt_addr_o(tgt_addr_o), .tgt_wdata_o(tgt_wdata_o),
   .wr_cfg_o(wr_cfg_o), .rd_cfg_o(rd_cfg_o), .wr_irq_req_o(wr_irq_req_o),
   .rd_irq_req_o(rd_irq_req_o), .wb_valid_o(wb_valid_o), .wb_addr_o(wb_addr_o),
   .wb_data_o(wb_data_o), .app_interrupt_vector_o(app_interrupt_vector_o),
   .app_interrupt_class_o(app_interrupt_class_o));
`default_nettype wire

//--- test/cdcs_host_model.sv
// Host requester model: issues BAR-decoded memory requests.
// Assumes a one-cycle registered completion for register reads.
`timescale 1ns/1ps
`default_nettype none
module cdcs_host_model
   import cdcs_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic cpl_valid_i,
   input wire logic [31:0] cpl_data_i,
   output var cdcs_req_t req_o
);
   initial req_o = '0;
   // Only memory BAR hits can be issued; ROM and I/O BARs never
   task automatic access(input logic wr, input logic [5:0] hit, input logic [31:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic ok);
      int n;
      q = 32'h0;
      ok = 1'b1;
      @(posedge core_clk_i);
      req_o <= {1'b1, wr, hit, a, d};
      @(posedge core_clk_i);
      // Scramble released fields so a stale request cannot look valid
      req_o <= {1'b0, ~req_o[70:0]};
      if (!wr && (hit[2] || hit[3]) && !(hit[0] || hit[1] || hit[4] || hit[5])) begin
         ok = 1'b0;
         for (n = 0; n < 4 && !ok; n++) begin
            #1;
            if (cpl_valid_i === 1'b1) begin
               q = cpl_data_i;
               ok = 1'b1;
            end else @(posedge core_clk_i);
         end
      end
   endtask
endmodule
`default_nettype wire

//--- test/tb_cdcs_regs.sv
// Self-checking bench for the DMA control/status register block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_cdcs_regs
   import cdcs_pkg::*;
   ;
   typedef struct {
      logic [1:0] kind;
      logic [5:0] hit;
      logic [31:0] addr;
      logic [31:0] data;
      logic [31:0] exp;
   } cdcs_row_t;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ecrc_fwd_en_i = 1'b0;
   logic ecrc_err_i = 1'b0;
   cdcs_prog_t wr_prog_i = 19'h0_0001;
   cdcs_prog_t rd_prog_i = 19'h0_0001;
   cdcs_req_t req_i;
   cdcs_cfg_t wr_cfg_o, rd_cfg_o;
   logic cpl_valid_o, tgt_valid_o, tgt_write_o, wr_irq_req_o, rd_irq_req_o, wb_valid_o, ok;
   logic [31:0] cpl_data_o, tgt_wdata_o, wb_data_o, q, q1;
   logic [TGT_ADDR_W-1:0] tgt_addr_o;
   logic [63:0] wb_addr_o;
   logic [4:0] vec;
   logic [2:0] tcls;
   int fails = 0;
   int cmp_count = 0;
   // Kind 0 write then read, 1 read only, 2 target write
   cdcs_row_t rows [16] = '{
      '{2'h1, 6'h04, 32'h0000, 32'h0, 32'h0010_0000}, '{2'h1, 6'h04, 32'h0010, 32'h0, 32'h0},
      '{2'h0, 6'h04, 32'h0000, 32'hF1F6_0003, 32'hF1F6_0003},
      '{2'h0, 6'h08, 32'h0004, 32'h1234_5678, 32'h1234_5678},
      '{2'h0, 6'h0C, 32'h0008, 32'h0000_1000, 32'h0000_1000},
      '{2'h0, 6'h04, 32'h000C, 32'h0000_0002, 32'h0000_0002},
      '{2'h0, 6'h04, 32'h0010, 32'h3026_0004, 32'h3026_0004},
      '{2'h0, 6'h08, 32'h0014, 32'h0000_0001, 32'h0000_0001},
      '{2'h0, 6'h04, 32'h0018, 32'h0000_2000, 32'h0000_2000},
      '{2'h0, 6'h04, 32'h001C, 32'h0000_0003, 32'h0000_0003},
      '{2'h0, 6'h04, 32'h0020, 32'hFFFF_FFFF, 32'h0001_0000},
      '{2'h0, 6'h04, 32'h0030, 32'hFFFF_FFFF, 32'h0},
      '{2'h0, 6'h04, 32'h0040, 32'hFFFF_FFFF, 32'h0},
      '{2'h1, 6'h04, 32'h0100, 32'h0, 32'hF1F6_0003},
      '{2'h2, 6'h05, 32'h7FFC, 32'hA5A5_5A5A, 32'h7FFC},
      '{2'h2, 6'h30, 32'h8004, 32'h0F0F_0F0F, 32'h0004}};

   always #5 core_clk_i = ~core_clk_i;

   cdcs_regs u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
      .wr_prog_i(wr_prog_i), .rd_prog_i(rd_prog_i), .ecrc_fwd_en_i(ecrc_fwd_en_i),
      .ecrc_err_i(ecrc_err_i), .cpl_valid_o(cpl_valid_o), .cpl_data_o(cpl_data_o),
      .tgt_valid_o(tgt_valid_o), .tgt_write_o(tgt_write_o), .tgt_addr_o(tgt_addr_o),
      .tgt_wdata_o(tgt_wdata_o), .wr_cfg_o(wr_cfg_o), .rd_cfg_o(rd_cfg_o),
      .wr_irq_req_o(wr_irq_req_o), .rd_irq_req_o(rd_irq_req_o), .wb_valid_o(wb_valid_o),
      .wb_addr_o(wb_addr_o), .wb_data_o(wb_data_o),
      .app_interrupt_vector_o(vec), .app_interrupt_class_o(tcls));
   cdcs_host_model u_host (.core_clk_i(core_clk_i), .cpl_valid_i(cpl_valid_o),
      .cpl_data_i(cpl_data_o), .req_o(req_i));

   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [5:0] h, input logic [31:0] a, d);
      u_host.access(w, h, a, d, q, ok);
      if (!ok) begin
         fails++;
         $display("BAD %0t no completion", $time);
         finish_test();
      end
   endtask
   // Leaves the caller one step past the edge where the answers land
   task automatic pulse(input logic w, r, input logic [15:0] wi, ri);
      @(posedge core_clk_i);
      wr_prog_i <= {1'b0, w, wi, wr_prog_i.fifo_empty};
      rd_prog_i <= {1'b0, r, ri, rd_prog_i.fifo_empty};
      @(posedge core_clk_i);
      wr_prog_i.desc_done <= 1'b0;
      rd_prog_i.desc_done <= 1'b0;
      #1;
   endtask

   initial begin
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].kind == 2'h2) begin
            acc(1'b1, rows[i].hit, rows[i].addr, rows[i].data);
            #1;
            check({tgt_valid_o, tgt_addr_o, tgt_wdata_o},
               {1'b1, rows[i].exp[14:0], rows[i].data});
         end else begin
            if (rows[i].kind == 2'h0) acc(1'b1, rows[i].hit, rows[i].addr, rows[i].data);
            acc(1'b0, rows[i].hit, rows[i].addr, 32'h0);
            check(q, rows[i].exp);
         end
      end
      // Both engines run and complete a descriptor in the same cycle; only the read engine stops, the write engine loops
      @(posedge core_clk_i);
      wr_prog_i <= 19'h4_0000;
      rd_prog_i <= 19'h4_0001;
      @(posedge core_clk_i);
      wr_prog_i.start <= 1'b0;
      rd_prog_i.start <= 1'b0;
      repeat (8) @(posedge core_clk_i);
      pulse(1'b1, 1'b1, 16'h0002, 16'h0003);
      check({wb_valid_o, wb_data_o, rd_irq_req_o, wr_irq_req_o}, {1'b1, 32'h3, 2'h3});
      check(wb_addr_o, 64'h0000_0001_0000_200C);
      @(posedge core_clk_i);
      #1;
      check({wb_valid_o, wb_data_o}, {1'b1, 32'h2});
      check(wb_addr_o, 64'h1234_5678_0000_100C);
      check({vec, tcls}, {5'h02, 3'h3});
      pulse(1'b1, 1'b0, 16'h0002, 16'h0);
      @(posedge core_clk_i);
      #1;
      check({vec, tcls}, {5'h1F, 3'h7});
      acc(1'b0, 6'h04, 32'h20, 32'h0);
      check(q, 32'h0000_0002);
      acc(1'b0, 6'h04, 32'h28, 32'h0);
      check(q, 32'h0001_0003);
      acc(1'b0, 6'h04, 32'h2C, 32'h0);
      q1 = q;
      acc(1'b0, 6'h04, 32'h2C, 32'h0);
      check({q1[31:24], q1 == q, q1[23:0] != 24'h0}, {8'h20, 2'h3});
      acc(1'b0, 6'h04, 32'h24, 32'h0);
      q1 = q;
      acc(1'b0, 6'h04, 32'h24, 32'h0);
      check({q1[31:24], q[23:0] > q1[23:0]}, {8'h0F, 1'b1});
      // Interrupt and write-back switched off
      acc(1'b1, 6'h04, 32'h00, 32'h0000_0003);
      pulse(1'b1, 1'b0, 16'h0005, 16'h0);
      check({wb_valid_o, wr_irq_req_o}, 2'h0);
      // Errors only count while forwarding is on
      for (int k = 0; k < 5; k++) begin
         @(posedge core_clk_i);
         ecrc_fwd_en_i <= (k > 1);
         ecrc_err_i <= 1'b1;
         @(posedge core_clk_i);
         ecrc_err_i <= 1'b0;
      end
      acc(1'b0, 6'h04, 32'h30, 32'h0);
      check(q, 32'h0000_0003);
      @(posedge core_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      acc(1'b0, 6'h04, 32'h00, 32'h0);
      check(q, 32'h0010_0000);
      acc(1'b0, 6'h04, 32'h1C, 32'h0);
      check(q, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
